// ==== verilog/uart_pkg.sv ====
// Constants, register map and carrier types of the enhanced serial port.
// Assumes a 10 MHz core clock and an APB master with 32-bit data.
`default_nettype none
package uart_pkg;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DATA = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_MASK = 8'h0C;
  localparam logic [7:0] OFF_ADDR = 8'h10;
  localparam int CTRL_RX_DONE = 0;
  localparam int CTRL_TX_DONE = 1;
  localparam int CTRL_RB8 = 2;
  localparam int CTRL_TB8 = 3;
  localparam int CTRL_REN = 4;
  localparam int CTRL_MPE = 5;
  localparam int CTRL_MODE = 6;
  localparam int CTRL_DBL = 8;
  localparam int ST_RX = 0;
  localparam int ST_TX = 1;
  localparam int ST_OVR = 2;
  localparam int ST_FERR = 3;
  localparam int N_EV = 4;
  localparam int CLK_HZ = 10_000_000;
  localparam int SYNC_DIV = 12;
  localparam logic [3:0] SYNC_HIGH_AT = 4'(SYNC_DIV / 2);
  localparam logic [3:0] SYNC_BIT_LAST = 4'(SYNC_DIV - 1);
  localparam logic [3:0] OS_LAST = 4'hF;
  localparam logic [3:0] SAMPLE_AT = 4'h7;
  localparam logic [3:0] BITS_8 = 4'hA;
  localparam logic [3:0] BITS_9 = 4'hB;
  localparam logic [3:0] SYNC_BITS = 4'h8;
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  typedef enum logic [1:0] {
    MODE_SYNC = 2'h0, MODE_ASYNC8 = 2'h1, MODE_FIXED9 = 2'h2, MODE_VAR9 = 2'h3
  } mode_t;
  typedef struct packed {
    logic double_speed;
    mode_t mode;
    logic multiproc_enable;
    logic rx_enable_bit;
    logic tx_ninth_bit;
  } cfg_t;
  localparam cfg_t CFG_RESET = '{1'b0, MODE_SYNC, 1'b0, 1'b0, 1'b0};
  typedef enum logic [3:0] {
    LNK_IDLE = 4'h1, LNK_ASYNC = 4'h2, LNK_SYNC_OUT = 4'h4, LNK_SYNC_IN = 4'h8
  } link_state_t;
  typedef enum logic [1:0] {RX_IDLE = 2'h1, RX_BUSY = 2'h2} rx_state_t;
endpackage
`default_nettype wire

// ==== verilog/enhanced_uart_core.sv ====
// Enhanced serial port: four modes, holding register, APB registers.
// Assumes baud_tick_i is a one-cycle timer overflow pulse on clk_i.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1 - Full-duplex async or half-duplex sync style chosen by control register mode bits.
// R2 - Received bytes go to a holding register so reception continues.
// R3 - Overrun bit sets when a new byte loads before the previous was read.
// R4 - One data address: write loads and starts transmitter, read returns holding register.
// R5 - Transmit-done flag at control bit 1 set when a byte finishes sending.
// R6 - Receive-done flag at control bit 0 set when a byte is received.
// R7 - Flags are cleared only by software, never by interrupt entry.
// R8 - One interrupt request while an enabled flag is set; polling also works.
// R9 - Hardware detects framing errors and recognises its own multiprocessor address.
// R10 - Modes: sync 8-bit at clock/12, async 8-bit timer, two async 9-bit.
// R11 - Sync mode: LSB first on input pin, clock on output pin, receive waits.
// R12 - Async load only if receive flag clear and multiprocessor condition holds.
// R13 - Fixed 9-bit mode runs at clock/64, or clock/32 with double speed.
// R14 - Reset clears both flags and overrun and idles the output line high.
module enhanced_uart_core (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic baud_tick_i,
  input wire logic serial_in_pin_i,
  output logic serial_in_pin_o,
  output logic serial_in_pin_oe_o,
  output logic serial_out_pin_o,
  output logic irq_o
);
  uart_pkg::cfg_t cfg, next_cfg;
  logic [uart_pkg::N_EV-1:0] flags, next_flags, mask, next_mask, ev, clr;
  logic [15:0] addr, next_addr;
  logic [7:0] rx_hold, next_rx_hold, rx_new;
  logic rx_ninth, next_rx_ninth, rx9_new, rx_unread, next_rx_unread;
  logic [31:0] next_prdata, rd_word;
  logic next_pready, next_pslverr, next_irq, hit;
  logic wr, rd, data_wr, load;
  logic tdiv, next_tdiv, half, next_half, base, os_tick;
  logic [2:0] sync;
  logic rxf, next_rxf, rxf_d;
  uart_pkg::link_state_t lst, next_lst;
  logic [10:0] lsh, next_lsh;
  logic [3:0] lcnt, next_lcnt, ltk, next_ltk, nbits;
  logic next_out, next_oe, tx_ev, sync_rx_ev;
  uart_pkg::rx_state_t rst_q, next_rst;
  logic [9:0] rsh, next_rsh;
  logic [3:0] rcnt, next_rcnt, rtk, next_rtk;
  logic async_done, ferr_ev, match, ok;
  logic [7:0] a_data;
  logic a_ninth;

  assign wr = psel_i && penable_i && pready_o && pwrite_i;
  assign rd = psel_i && penable_i && pready_o && !pwrite_i;
  assign data_wr = wr && (paddr_i == uart_pkg::OFF_DATA); // [R4]
  assign nbits = (cfg.mode == uart_pkg::MODE_ASYNC8) ? uart_pkg::BITS_8
                                                     : uart_pkg::BITS_9; // [R10]

  // Oversample tick: 16 per bit time
  always_comb begin
    next_tdiv = (cfg.mode == uart_pkg::MODE_FIXED9) ? !tdiv : 1'b0;
    base = (cfg.mode == uart_pkg::MODE_FIXED9) ? tdiv : baud_tick_i; // [R13]
    next_half = half ^ base;
    os_tick = base && (cfg.double_speed || half); // [R13]
    next_rxf = (sync[1] == sync[2]) ? sync[2] : rxf;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tdiv <= 1'b0;
      half <= 1'b0;
      sync <= 3'h7;
      rxf <= 1'b1;
      rxf_d <= 1'b1;
    end else begin
      tdiv <= next_tdiv;
      half <= next_half;
      sync <= {sync[1:0], serial_in_pin_i};
      rxf <= next_rxf;
      rxf_d <= rxf;
    end
  end

  // Link engine: async transmit and both sync directions
  always_comb begin
    next_lst = lst;
    next_lsh = lsh;
    next_lcnt = lcnt;
    next_ltk = ltk;
    tx_ev = 1'b0;
    sync_rx_ev = 1'b0;
    case (lst)
      uart_pkg::LNK_IDLE: begin
        next_ltk = 4'h0;
        next_lcnt = 4'h0;
        if (data_wr && cfg.mode == uart_pkg::MODE_SYNC) begin
          next_lst = uart_pkg::LNK_SYNC_OUT;
          next_lsh = {3'h7, pwdata_i[7:0]};
        end else if (data_wr) begin
          next_lst = uart_pkg::LNK_ASYNC;
          next_lsh = (cfg.mode == uart_pkg::MODE_ASYNC8) ? {2'h3, pwdata_i[7:0], 1'b0}
                     : {1'b1, cfg.tx_ninth_bit, pwdata_i[7:0], 1'b0};
        end else if (cfg.mode == uart_pkg::MODE_SYNC && cfg.rx_enable_bit
                     && !flags[uart_pkg::ST_RX]) begin
          next_lst = uart_pkg::LNK_SYNC_IN; // [R11]
          next_lsh = 11'h7FF;
        end
      end
      uart_pkg::LNK_ASYNC: begin
        if (os_tick) begin
          next_ltk = ltk + 4'h1;
          if (ltk == uart_pkg::OS_LAST) begin
            next_lsh = {1'b1, lsh[10:1]};
            next_lcnt = lcnt + 4'h1;
            tx_ev = (next_lcnt == nbits - 4'h1); // [R5]
            if (next_lcnt == nbits) begin
              next_lst = uart_pkg::LNK_IDLE;
            end
          end
        end
      end
      uart_pkg::LNK_SYNC_OUT, uart_pkg::LNK_SYNC_IN: begin
        next_ltk = (ltk == uart_pkg::SYNC_BIT_LAST) ? 4'h0 : ltk + 4'h1; // [R10]
        if (ltk == uart_pkg::SYNC_BIT_LAST) begin
          next_lsh = (lst == uart_pkg::LNK_SYNC_IN) ? {3'h7, rxf, lsh[7:1]}
                                                    : {1'b1, lsh[10:1]}; // [R11]
          next_lcnt = lcnt + 4'h1;
          if (next_lcnt == uart_pkg::SYNC_BITS) begin
            next_lst = uart_pkg::LNK_IDLE;
            tx_ev = (lst == uart_pkg::LNK_SYNC_OUT); // [R11]
            sync_rx_ev = (lst == uart_pkg::LNK_SYNC_IN);
          end
        end
      end
      default: next_lst = uart_pkg::LNK_IDLE;
    endcase
    if (next_lst == uart_pkg::LNK_ASYNC) begin
      next_out = next_lsh[0];
    end else if (next_lst == uart_pkg::LNK_IDLE) begin
      next_out = 1'b1; // [R14]
    end else begin
      next_out = (next_ltk >= uart_pkg::SYNC_HIGH_AT);
    end
    next_oe = (next_lst == uart_pkg::LNK_SYNC_OUT) && !next_lsh[0];
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lst <= uart_pkg::LNK_IDLE;
      lsh <= 11'h7FF;
      lcnt <= 4'h0;
      ltk <= 4'h0;
      serial_out_pin_o <= 1'b1; // [R14]
      serial_in_pin_oe_o <= 1'b0;
    end else begin
      lst <= next_lst;
      lsh <= next_lsh;
      lcnt <= next_lcnt;
      ltk <= next_ltk;
      serial_out_pin_o <= next_out;
      serial_in_pin_oe_o <= next_oe;
    end
  end

  // Async receiver, 16x oversampled, sampled mid-bit
  always_comb begin
    next_rst = rst_q;
    next_rsh = rsh;
    next_rcnt = rcnt;
    next_rtk = rtk;
    async_done = 1'b0;
    case (rst_q)
      uart_pkg::RX_IDLE: begin
        next_rtk = 4'h0;
        next_rcnt = 4'h0;
        if (cfg.mode != uart_pkg::MODE_SYNC && cfg.rx_enable_bit && rxf_d && !rxf) begin
          next_rst = uart_pkg::RX_BUSY;
        end
      end
      uart_pkg::RX_BUSY: begin
        if (os_tick) begin
          next_rtk = rtk + 4'h1;
          if (rtk == uart_pkg::SAMPLE_AT) begin
            next_rcnt = rcnt + 4'h1;
            if (rcnt == 4'h0 && rxf) begin
              next_rst = uart_pkg::RX_IDLE;
            end else if (next_rcnt == nbits) begin
              next_rst = uart_pkg::RX_IDLE;
              async_done = 1'b1;
            end else begin
              next_rsh = {rxf, rsh[9:1]};
            end
          end
        end
      end
      default: next_rst = uart_pkg::RX_IDLE;
    endcase
    if (cfg.mode == uart_pkg::MODE_ASYNC8) begin
      a_data = rsh[9:2];
      a_ninth = rxf;
    end else begin
      a_data = rsh[8:1];
      a_ninth = rsh[9];
    end
    match = ((a_data ^ addr[7:0]) & addr[15:8]) == 8'h00; // [R9]
    if (cfg.mode == uart_pkg::MODE_ASYNC8) begin
      ok = !cfg.multiproc_enable || rxf; // [R12]
    end else begin
      ok = !cfg.multiproc_enable || (a_ninth && match); // [R9]
    end
    ferr_ev = async_done && !rxf; // [R9]
    load = sync_rx_ev || (async_done && ok && !flags[uart_pkg::ST_RX]); // [R12]
    rx_new = sync_rx_ev ? {rxf, lsh[7:1]} : a_data;
    rx9_new = sync_rx_ev ? rx_ninth : a_ninth;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_q <= uart_pkg::RX_IDLE;
      rsh <= 10'h000;
      rcnt <= 4'h0;
      rtk <= 4'h0;
    end else begin
      rst_q <= next_rst;
      rsh <= next_rsh;
      rcnt <= next_rcnt;
      rtk <= next_rtk;
    end
  end

  // Register file, event flags and interrupt
  always_comb begin
    hit = 1'b1;
    case (paddr_i)
      uart_pkg::OFF_CTRL: rd_word = {23'h00_0000, cfg.double_speed, cfg.mode,
                                     cfg.multiproc_enable, cfg.rx_enable_bit,
                                     cfg.tx_ninth_bit, rx_ninth,
                                     flags[uart_pkg::ST_TX], flags[uart_pkg::ST_RX]};
      uart_pkg::OFF_DATA: rd_word = {24'h00_0000, rx_hold}; // [R4]
      uart_pkg::OFF_STAT: rd_word = {28'h000_0000, flags};
      uart_pkg::OFF_MASK: rd_word = {28'h000_0000, mask};
      uart_pkg::OFF_ADDR: rd_word = {16'h0000, addr};
      default: begin
        rd_word = 32'h0000_0000;
        hit = 1'b0;
      end
    endcase
    next_pready = psel_i && !penable_i;
    next_prdata = (psel_i && !penable_i && !pwrite_i) ? rd_word : prdata_o;
    next_pslverr = psel_i && !penable_i && !hit;
    next_cfg = cfg;
    next_mask = mask;
    next_addr = addr;
    clr = '0;
    if (wr && paddr_i == uart_pkg::OFF_CTRL) begin
      next_cfg = {pwdata_i[uart_pkg::CTRL_DBL], pwdata_i[uart_pkg::CTRL_MODE +: 2],
                  pwdata_i[uart_pkg::CTRL_MPE], pwdata_i[uart_pkg::CTRL_REN],
                  pwdata_i[uart_pkg::CTRL_TB8]}; // [R1]
      clr[uart_pkg::ST_RX] = !pwdata_i[uart_pkg::CTRL_RX_DONE]; // [R7]
      clr[uart_pkg::ST_TX] = !pwdata_i[uart_pkg::CTRL_TX_DONE]; // [R7]
    end
    if (wr && paddr_i == uart_pkg::OFF_STAT) begin
      clr = clr | pwdata_i[uart_pkg::N_EV-1:0];
    end
    if (wr && paddr_i == uart_pkg::OFF_MASK) begin
      next_mask = pwdata_i[uart_pkg::N_EV-1:0];
    end
    if (wr && paddr_i == uart_pkg::OFF_ADDR) begin
      next_addr = pwdata_i[15:0];
    end
    ev = '0;
    ev[uart_pkg::ST_RX] = load; // [R6]
    ev[uart_pkg::ST_TX] = tx_ev; // [R5]
    ev[uart_pkg::ST_OVR] = load && rx_unread; // [R3]
    ev[uart_pkg::ST_FERR] = ferr_ev;
    next_flags = (flags & ~clr) | ev; // [R7]
    next_rx_hold = load ? rx_new : rx_hold; // [R2]
    next_rx_ninth = load ? rx9_new : rx_ninth;
    next_rx_unread = load || (rx_unread && !(rd && paddr_i == uart_pkg::OFF_DATA));
    next_irq = |(next_flags & next_mask); // [R8]
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg <= uart_pkg::CFG_RESET;
      flags <= '0; // [R14]
      mask <= uart_pkg::MASK_RESET;
      addr <= uart_pkg::ADDR_RESET;
      rx_hold <= 8'h00;
      rx_ninth <= 1'b0;
      rx_unread <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      irq_o <= 1'b0;
      serial_in_pin_o <= 1'b0;
    end else begin
      cfg <= next_cfg;
      flags <= next_flags;
      mask <= next_mask;
      addr <= next_addr;
      rx_hold <= next_rx_hold;
      rx_ninth <= next_rx_ninth;
      rx_unread <= next_rx_unread;
      prdata_o <= next_prdata;
      pready_o <= next_pready;
      pslverr_o <= next_pslverr;
      irq_o <= next_irq;
      serial_in_pin_o <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence clk_low_s;
    !serial_out_pin_o [*6];
  endsequence
  sequence clk_high_s;
    serial_out_pin_o [*6];
  endsequence

  tx_done_set_a: assert property (tx_ev |=> flags[uart_pkg::ST_TX]) // [R5]
    else $error("transmit-done flag not set after frame");
  rx_load_data_a: assert property (load |=> flags[uart_pkg::ST_RX]
      && rx_hold == $past(rx_new)) // [R6]
    else $error("received byte not held with flag");
  overrun_set_a: assert property (load && rx_unread |=> flags[uart_pkg::ST_OVR]) // [R3]
    else $error("overrun not flagged");
  flag_sticky_a: assert property (flags[uart_pkg::ST_RX] && !wr
      |=> flags[uart_pkg::ST_RX]) // [R7]
    else $error("receive flag cleared without software");
  irq_follow_a: assert property ((|(flags & mask)) && !wr |=> irq_o) // [R8]
    else $error("interrupt not raised for enabled flag");
  no_reload_a: assert property (flags[uart_pkg::ST_RX] && async_done
      |-> !load) // [R12]
    else $error("byte loaded while receive flag set");
  idle_line_a: assert property (lst == uart_pkg::LNK_IDLE |-> serial_out_pin_o) // [R14]
    else $error("output line not idle high");
  sync_clock_a: assert property (lst == uart_pkg::LNK_IDLE
      && next_lst == uart_pkg::LNK_SYNC_OUT |=> clk_low_s ##1 clk_high_s) // [R11]
    else $error("shift clock not twelve cycles per bit");
  hold_stable_a: assert property (!load |=> $stable(rx_hold)) // [R2]
    else $error("holding register changed without a load");
endmodule // enhanced_uart_core
`default_nettype wire

// ==== tb/serial_peer.sv ====
// Far-side asynchronous transceiver, fixed-rate 9-bit framing.
// Assumes 64 core clocks per bit, i.e. double speed left off.
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
  input wire logic clk_i,
  input wire logic line_i,
  output logic line_o,
  output logic [8:0] got_o
);
  initial begin
    line_o = 1'b1;
    got_o = 9'h000;
  end
  // Capture: mid-bit samples, LSB first, ninth bit last
  always begin
    @(negedge line_i);
    repeat (32) @(posedge clk_i);
    for (int i = 0; i < 9; i++) begin
      repeat (64) @(posedge clk_i);
      got_o = {line_i, got_o[8:1]};
    end
    repeat (64) @(posedge clk_i);
  end
  // Frame: start, 8 data LSB first, ninth, stop
  task automatic send(input logic [7:0] b, input logic n9, input logic stop);
    logic [10:0] f;
    f = {stop, n9, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      line_o <= f[i];
      repeat (64) @(posedge clk_i);
    end
    line_o <= 1'b1;
  endtask
endmodule // serial_peer
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench of the enhanced serial port over APB.
// Assumes the peer model on the serial pins; timer tick held low.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic pin_o;
  logic pin_oe;
  logic serial_out_pin_o;
  logic irq_o;
  logic peer_line;
  logic [8:0] got;
  wire logic pin_level = (pin_oe ? pin_o : 1'b1) & peer_line;
  logic [31:0] rd;
  logic [7:0] sync_byte = 8'h00;
  int n_errors = 0;
  int comparisons = 0;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic e;} row_t;
  row_t rows [5] = '{
    '{uart_pkg::OFF_CTRL, 32'h0000_0000, 1'b0},
    '{uart_pkg::OFF_STAT, 32'h0000_0000, 1'b0},
    '{uart_pkg::OFF_MASK, 32'h0000_0000, 1'b0},
    '{uart_pkg::OFF_ADDR, 32'h0000_0000, 1'b0},
    '{8'h14, 32'h0000_0000, 1'b1}};

  always #50 clk_i = ~clk_i;

  enhanced_uart_core enhanced_uart_core_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .baud_tick_i(1'b0),
    .serial_in_pin_i(pin_level), .serial_in_pin_o(pin_o),
    .serial_in_pin_oe_o(pin_oe), .serial_out_pin_o(serial_out_pin_o), .irq_o(irq_o)
  );
  serial_peer serial_peer_i (
    .clk_i(clk_i), .line_i(serial_out_pin_o), .line_o(peer_line), .got_o(got)
  );

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask

  // One APB transfer; entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk_i);
      if (pready_o === 1'b1) break;
    end
    rd = pslverr_o ? 32'hFFFF_FFFF : prdata_o;
    if (pslverr_o === 1'b0) rd = prdata_o;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 16) begin
      n_errors++;
      print_verdict();
    end
    @(posedge clk_i);
  endtask

  task automatic wait_irq();
    int n;
    for (n = 0; n < 2000; n++) begin
      @(posedge clk_i);
      if (irq_o === 1'b1) break;
    end
    if (n == 2000) begin
      n_errors++;
      print_verdict();
    end
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    foreach (rows[i]) begin
      apb(1'b0, rows[i].a, 32'h0000_0000);
      chk(rd, rows[i].e ? 32'hFFFF_FFFF : rows[i].d);
    end
    chk({31'h0000_0000, serial_out_pin_o}, 32'h0000_0001);
    $display("test reset values done");
    apb(1'b1, uart_pkg::OFF_CTRL, 32'h0000_0098);
    apb(1'b1, uart_pkg::OFF_MASK, 32'h0000_0003);
    apb(1'b1, uart_pkg::OFF_DATA, 32'h0000_00A5);
    wait_irq();
    repeat (200) @(posedge clk_i);
    chk({23'h00_0000, got}, 32'h0000_01A5);
    apb(1'b0, uart_pkg::OFF_CTRL, 32'h0000_0000);
    chk(rd & 32'h0000_0003, 32'h0000_0002);
    chk({31'h0000_0000, irq_o}, 32'h0000_0001);
    apb(1'b1, uart_pkg::OFF_STAT, 32'h0000_0002);
    chk({31'h0000_0000, irq_o}, 32'h0000_0000);
    $display("test transmit done");
    serial_peer_i.send(8'h3C, 1'b1, 1'b1);
    wait_irq();
    apb(1'b0, uart_pkg::OFF_CTRL, 32'h0000_0000);
    chk(rd & 32'h0000_0007, 32'h0000_0005);
    apb(1'b0, uart_pkg::OFF_DATA, 32'h0000_0000);
    chk(rd, 32'h0000_003C);
    apb(1'b1, uart_pkg::OFF_STAT, 32'h0000_0001);
    $display("test receive done");
    serial_peer_i.send(8'h11, 1'b0, 1'b1);
    wait_irq();
    apb(1'b1, uart_pkg::OFF_STAT, 32'h0000_0001);
    serial_peer_i.send(8'h22, 1'b0, 1'b1);
    wait_irq();
    apb(1'b0, uart_pkg::OFF_STAT, 32'h0000_0000);
    chk(rd, 32'h0000_0005);
    serial_peer_i.send(8'h33, 1'b0, 1'b0);
    repeat (100) @(posedge clk_i);
    apb(1'b0, uart_pkg::OFF_DATA, 32'h0000_0000);
    chk(rd, 32'h0000_0022);
    apb(1'b0, uart_pkg::OFF_STAT, 32'h0000_0000);
    chk(rd & 32'h0000_0008, 32'h0000_0008);
    $display("test overrun and frame error done");
    rst_n_i <= 1'b0;
    @(posedge clk_i);
    chk({30'h0000_0000, serial_out_pin_o, irq_o}, 32'h0000_0002);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    apb(1'b0, uart_pkg::OFF_STAT, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    $display("test mid-run reset done");
    apb(1'b1, uart_pkg::OFF_MASK, 32'h0000_0003);
    apb(1'b1, uart_pkg::OFF_DATA, 32'h0000_005A);
    // Mode 0 after reset: one sample per 12-clock bit, early in the low half
    for (int b = 0; b < 8; b++) begin
      chk({31'h0000_0000, serial_out_pin_o}, 32'h0000_0000);
      sync_byte = {pin_level, sync_byte[7:1]};
      repeat (12) @(posedge clk_i);
    end
    chk({24'h00_0000, sync_byte}, 32'h0000_005A);
    chk({31'h0000_0000, irq_o}, 32'h0000_0001);
    chk({31'h0000_0000, serial_out_pin_o}, 32'h0000_0001);
    $display("test sync transmit done");
    print_verdict();
  end
endmodule // tb
`default_nettype wire
